// *** hdl/gioa_defs.vh ***
// constants of the guidance i/o adapter port
`ifndef GIOA_DEFS_VH
`define GIOA_DEFS_VH

// ****************************************
// word and timing
// ****************************************
`define GIOA_WORD_W 28
`define GIOA_BITCNT_W 5
`define GIOA_CLK_NS 4
`define GIOA_NS_PER_S 1000000000
`define GIOA_TLM_MAX_PER_S 240
`define GIOA_TIMER_PERIOD_NS 1000000
`define GIOA_INIT_HOLD_NS 4000

// ****************************************
// sizes
// ****************************************
`define GIOA_INT_N 4
`define GIOA_DLINE_DEPTH 16
`define GIOA_INT_DLY 8

// ****************************************
// select codes
// ****************************************
`define GIOA_SEL_DLINE 8'h01
`define GIOA_SEL_COUNTER 8'h02
`define GIOA_SEL_DISCRETE 8'h03
`define GIOA_SEL_TLM 8'h04
`define GIOA_SEL_INTSTAT 8'h05

// ****************************************
// direction line and reset values
// ****************************************
`define GIOA_DIR_TO_COMP 1'b1
`define GIOA_DOUT_RST 28'h0000000
`define GIOA_CNT_RST 28'h0000000

`endif

// *** hdl/gioa_dline.v ***
// circulating delay line store, oldest word at the head
`timescale 1ns/10ps
module gioa_dline #(
  parameter WIDTH = 28,
  parameter DEPTH = 16
) (
  // clock and control
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  // data
  input wire push_in,
  input wire [WIDTH-1:0] data_in,
  output wire [WIDTH-1:0] head_out
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] ptr_reg;
  wire [AW:0] ptr_inc;
  wire [AW-1:0] ptr_next;
  integer i;

  assign ptr_inc = {1'b0, ptr_reg} + {{AW{1'b0}}, 1'b1};
  assign ptr_next = (ptr_reg == DEPTH - 1) ? {AW{1'b0}} : ptr_inc[AW-1:0];
  assign head_out = mem[ptr_reg];

  // ****************************************
  // push: oldest word leaves, new word enters
  // ****************************************
  always @(posedge clk_in) begin
    if (rst_in) begin
      ptr_reg <= {AW{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else if (ce_in && push_in) begin
      mem[ptr_reg] <= data_in;
      ptr_reg <= ptr_next;
    end
  end
endmodule // gioa_dline

// *** hdl/gioa_port.v ***
// adapter side of the computer i/o port: select decode, serial words, devices
// What this block does
// - eight-line select code names the device; adapter decodes it
// - separate direction line marks input to or output from the computer
// - one interrupt output is the OR of discrete interrupt inputs
// - adapter also makes its own periodic timed interrupt
// - each word moves bit-serially on one input or one output line
// - decoded selection routes written words to, and reads words from, a device
// - delay line, counter and discrete buffers each have their own code
// - discrete inputs pack into a read word; written word sets discrete outputs
// - dedicated signals control computer start-up and initialisation
// - telemetry words leave no faster than 240 per second
// - a serial word is 28 bits long
// - discrete interrupts pass a delay line before reaching the computer
`timescale 1ns/10ps
`include "gioa_defs.vh"
module gioa_port #(
  parameter WORD_W = `GIOA_WORD_W,
  parameter INT_N = `GIOA_INT_N,
  parameter DLINE_DEPTH = `GIOA_DLINE_DEPTH,
  parameter INT_DLY = `GIOA_INT_DLY,
  parameter TLM_MIN_CYC = (`GIOA_NS_PER_S + `GIOA_TLM_MAX_PER_S * `GIOA_CLK_NS - 1) /
    (`GIOA_TLM_MAX_PER_S * `GIOA_CLK_NS),
  parameter TIMER_CYC = `GIOA_TIMER_PERIOD_NS / `GIOA_CLK_NS,
  parameter INIT_HOLD_CYC = (`GIOA_INIT_HOLD_NS + `GIOA_CLK_NS - 1) / `GIOA_CLK_NS
) (
  // clock, reset, enable
  input wire MCLK_IN,
  input wire RST_IN,
  input wire CE_IN,
  // computer link
  input wire BIT_CLK_IN,
  input wire XFER_IN,
  input wire [7:0] SEL_IN,
  input wire DIR_IN,
  input wire SER_DATA_IN,
  output reg SER_DATA_OUT,
  output reg INTR_OUT,
  // computer start-up
  input wire INIT_REQ_IN,
  output reg COMP_INIT_OUT,
  output reg COMP_RUN_OUT,
  // discrete signals and events
  input wire [INT_N-1:0] INT_SRC_IN,
  input wire [WORD_W-1:0] DISC_IN,
  output reg [WORD_W-1:0] DISC_OUT,
  input wire COUNT_PULSE_IN,
  // telemetry
  output reg [WORD_W-1:0] TLM_DATA_OUT,
  output reg TLM_STB_OUT
);
  // ****************************************
  // input synchronisers
  // ****************************************
  localparam SW = 14 + INT_N + WORD_W;
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SHIFT = 2'd1;
  localparam [1:0] ST_DONE = 2'd2;
  localparam [4:0] LAST_BIT = WORD_W - 1;

  reg [SW-1:0] meta_reg;
  reg [SW-1:0] sync_reg;
  wire [SW-1:0] async_vec;
  wire bclk_s, xfer_s, sdi_s, dir_s, cnt_s, init_s;
  wire [7:0] sel_s;
  wire [INT_N-1:0] int_s;
  wire [WORD_W-1:0] disc_s;

  assign async_vec = {BIT_CLK_IN, XFER_IN, SER_DATA_IN, DIR_IN, SEL_IN, COUNT_PULSE_IN,
    INIT_REQ_IN, INT_SRC_IN, DISC_IN};
  assign {bclk_s, xfer_s, sdi_s, dir_s, sel_s, cnt_s, init_s, int_s, disc_s} = sync_reg;

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      meta_reg <= {SW{1'b0}};
      sync_reg <= {SW{1'b0}};
    end else if (CE_IN) begin
      meta_reg <= async_vec;
      sync_reg <= meta_reg;
    end
  end

  // ****************************************
  // edge detection on synchronised lines
  // ****************************************
  reg bclk_d_reg, xfer_d_reg, cnt_d_reg;
  wire bit_rise, xfer_rise, cnt_rise;

  assign bit_rise = bclk_s & ~bclk_d_reg;
  assign xfer_rise = xfer_s & ~xfer_d_reg;
  assign cnt_rise = cnt_s & ~cnt_d_reg;

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      bclk_d_reg <= 1'b0;
      xfer_d_reg <= 1'b0;
      cnt_d_reg <= 1'b0;
    end else if (CE_IN) begin
      bclk_d_reg <= bclk_s;
      xfer_d_reg <= xfer_s;
      cnt_d_reg <= cnt_s;
    end
  end

  // ****************************************
  // word transfer sequencer
  // ****************************************
  reg [1:0] state_reg;
  reg [7:0] xsel_reg;
  reg xdir_reg;
  reg [4:0] bitcnt_reg;
  reg [WORD_W-1:0] shift_reg;
  reg [WORD_W-1:0] read_word;
  wire word_end;
  wire [WORD_W-1:0] end_word;
  wire wr_end, rd_end;

  assign word_end = (state_reg == ST_SHIFT) && xfer_s && bit_rise &&
    (bitcnt_reg == LAST_BIT);
  assign end_word = {shift_reg[WORD_W-2:0], sdi_s};
  assign wr_end = word_end && (xdir_reg != `GIOA_DIR_TO_COMP);
  assign rd_end = word_end && (xdir_reg == `GIOA_DIR_TO_COMP);

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
      xsel_reg <= 8'h00;
      xdir_reg <= 1'b0;
      bitcnt_reg <= 5'h00;
      shift_reg <= {WORD_W{1'b0}};
      SER_DATA_OUT <= 1'b0;
    end else if (CE_IN) begin
      case (state_reg)
        ST_IDLE: begin
          SER_DATA_OUT <= 1'b0;
          if (xfer_rise) begin
            xsel_reg <= sel_s;
            xdir_reg <= dir_s;
            bitcnt_reg <= 5'h00;
            if (dir_s == `GIOA_DIR_TO_COMP) begin
              shift_reg <= read_word;
              SER_DATA_OUT <= read_word[WORD_W-1];
            end else begin
              shift_reg <= {WORD_W{1'b0}};
            end
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!xfer_s) begin
            // frame dropped early: partial word discarded
            state_reg <= ST_IDLE;
            SER_DATA_OUT <= 1'b0;
          end else if (bit_rise) begin
            shift_reg <= end_word;
            bitcnt_reg <= bitcnt_reg + 5'h01;
            if (xdir_reg == `GIOA_DIR_TO_COMP) begin
              SER_DATA_OUT <= shift_reg[WORD_W-2];
            end
            if (bitcnt_reg == LAST_BIT) begin
              state_reg <= ST_DONE;
              SER_DATA_OUT <= 1'b0;
            end
          end
        end
        ST_DONE: begin
          SER_DATA_OUT <= 1'b0;
          if (!xfer_s) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          SER_DATA_OUT <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // delay line device and interrupt buffer
  // ****************************************
  wire [WORD_W-1:0] dl_head;
  wire dl_push;
  wire [WORD_W-1:0] dl_din;
  wire [INT_N-1:0] int_dly;

  assign dl_push = word_end && (xsel_reg == `GIOA_SEL_DLINE);
  assign dl_din = wr_end ? end_word : dl_head;

  gioa_dline #(
    .WIDTH(WORD_W),
    .DEPTH(DLINE_DEPTH)
  ) u_dline (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .push_in(dl_push),
    .data_in(dl_din),
    .head_out(dl_head)
  );

  gioa_dline #(
    .WIDTH(INT_N),
    .DEPTH(INT_DLY)
  ) u_int_dline (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .push_in(1'b1),
    .data_in(int_s),
    .head_out(int_dly)
  );

  // ****************************************
  // counter, discrete outputs, timer
  // ****************************************
  reg [WORD_W-1:0] count_reg;
  reg [31:0] timer_reg;
  reg timer_flag_reg;
  wire timer_tick;
  wire timer_clr;

  assign timer_tick = (timer_reg == 32'h00000000);
  assign timer_clr = rd_end && (xsel_reg == `GIOA_SEL_INTSTAT);

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      count_reg <= `GIOA_CNT_RST;
      DISC_OUT <= `GIOA_DOUT_RST;
      timer_reg <= TIMER_CYC - 1;
      timer_flag_reg <= 1'b0;
      INTR_OUT <= 1'b0;
    end else if (CE_IN) begin
      if (wr_end && (xsel_reg == `GIOA_SEL_COUNTER)) begin
        count_reg <= end_word;
      end else if (cnt_rise) begin
        count_reg <= count_reg + {{(WORD_W-1){1'b0}}, 1'b1};
      end
      if (wr_end && (xsel_reg == `GIOA_SEL_DISCRETE)) begin
        DISC_OUT <= end_word;
      end
      timer_reg <= timer_tick ? TIMER_CYC - 1 : timer_reg - 32'h00000001;
      if (timer_tick) begin
        timer_flag_reg <= 1'b1;
      end else if (timer_clr) begin
        timer_flag_reg <= 1'b0;
      end
      INTR_OUT <= (|int_dly) | timer_flag_reg;
    end
  end

  // ****************************************
  // read word selection
  // ****************************************
  always @* begin
    read_word = {WORD_W{1'b0}};
    case (sel_s)
      `GIOA_SEL_DLINE: read_word = dl_head;
      `GIOA_SEL_COUNTER: read_word = count_reg;
      `GIOA_SEL_DISCRETE: read_word = disc_s;
      `GIOA_SEL_INTSTAT: read_word[INT_N:0] = {timer_flag_reg, int_dly};
      default: read_word = {WORD_W{1'b0}};
    endcase
  end

  // ****************************************
  // telemetry with rate limit
  // ****************************************
  reg [31:0] tlm_gap_reg;
  reg [WORD_W-1:0] tlm_pend_reg;
  reg tlm_pend_valid_reg;
  wire tlm_wr;
  wire tlm_ok;

  assign tlm_wr = wr_end && (xsel_reg == `GIOA_SEL_TLM);
  assign tlm_ok = (tlm_gap_reg == 32'h00000000);

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      tlm_gap_reg <= 32'h00000000;
      tlm_pend_reg <= {WORD_W{1'b0}};
      tlm_pend_valid_reg <= 1'b0;
      TLM_DATA_OUT <= {WORD_W{1'b0}};
      TLM_STB_OUT <= 1'b0;
    end else if (CE_IN) begin
      TLM_STB_OUT <= 1'b0;
      if (!tlm_ok) begin
        tlm_gap_reg <= tlm_gap_reg - 32'h00000001;
      end
      if (tlm_wr) begin
        // newest word replaces a still-waiting one
        tlm_pend_reg <= end_word;
        tlm_pend_valid_reg <= 1'b1;
      end else if (tlm_pend_valid_reg && tlm_ok) begin
        TLM_DATA_OUT <= tlm_pend_reg;
        TLM_STB_OUT <= 1'b1;
        tlm_pend_valid_reg <= 1'b0;
        tlm_gap_reg <= TLM_MIN_CYC - 1;
      end
    end
  end

  // ****************************************
  // computer start-up control
  // ****************************************
  reg [31:0] init_cnt_reg;

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      init_cnt_reg <= INIT_HOLD_CYC;
      COMP_INIT_OUT <= 1'b1;
      COMP_RUN_OUT <= 1'b0;
    end else if (CE_IN) begin
      if (init_s) begin
        init_cnt_reg <= INIT_HOLD_CYC;
        COMP_INIT_OUT <= 1'b1;
        COMP_RUN_OUT <= 1'b0;
      end else if (init_cnt_reg != 32'h00000000) begin
        init_cnt_reg <= init_cnt_reg - 32'h00000001;
        COMP_INIT_OUT <= 1'b1;
        COMP_RUN_OUT <= 1'b0;
      end else begin
        COMP_INIT_OUT <= 1'b0;
        COMP_RUN_OUT <= 1'b1;
      end
    end
  end
endmodule // gioa_port

// *** verif/gioa_port_monitor.sv ***
// concurrent checks on the adapter port pins
`timescale 1ns/10ps
`include "gioa_defs.vh"
module gioa_port_monitor #(
  parameter TLM_MIN_CYC = 50
) (
  // clock, reset
  input wire MCLK_IN,
  input wire RST_IN,
  // link and inputs
  input wire XFER_IN,
  input wire [7:0] SEL_IN,
  input wire DIR_IN,
  input wire INIT_REQ_IN,
  input wire [3:0] INT_SRC_IN,
  input wire [27:0] DISC_IN,
  // outputs
  input wire SER_DATA_OUT,
  input wire INTR_OUT,
  input wire COMP_INIT_OUT,
  input wire COMP_RUN_OUT,
  input wire [27:0] DISC_OUT,
  input wire [27:0] TLM_DATA_OUT,
  input wire TLM_STB_OUT
);
  // ****************************************
  // helper counters
  // ****************************************
  reg [3:0] age_reg;
  reg [31:0] gap_reg;
  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      age_reg <= 4'h0;
      gap_reg <= TLM_MIN_CYC;
    end else begin
      if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
      gap_reg <= TLM_STB_OUT ? 32'h1 : gap_reg + 32'h1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_held; COMP_INIT_OUT [*5]; endsequence
  sequence s_first; ##[3:5] SER_DATA_OUT == DISC_IN[27]; endsequence
  property p_run_inv; COMP_RUN_OUT != COMP_INIT_OUT; endproperty
  a_run_inv: assert property (p_run_inv) else $error("run not inverse of init");
  property p_init_hold; $fell(RST_IN) && !INIT_REQ_IN |-> s_held ##[1:8] COMP_RUN_OUT;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("start-up hold wrong");
  property p_tlm_gap; TLM_STB_OUT |-> gap_reg >= TLM_MIN_CYC; endproperty
  a_tlm_gap: assert property (p_tlm_gap) else $error("telemetry too fast");
  property p_tlm_data; $changed(TLM_DATA_OUT) |-> TLM_STB_OUT; endproperty
  a_tlm_data: assert property (p_tlm_data) else $error("telemetry without strobe");
  property p_intr;
    age_reg == 4'hf && |($past(INT_SRC_IN, 11) & $past(INT_SRC_IN, 12)) |-> INTR_OUT;
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt not raised");
  property p_ser_idle; !XFER_IN [*6] |-> !SER_DATA_OUT; endproperty
  a_ser_idle: assert property (p_ser_idle) else $error("serial out not idle");
  property p_disc_wr;
    $changed(DISC_OUT) |-> $past(XFER_IN, 4) && !$past(DIR_IN, 4) &&
      $past(SEL_IN, 4) == `GIOA_SEL_DISCRETE;
  endproperty
  a_disc_wr: assert property (p_disc_wr) else $error("discrete out wrongly set");
  property p_ser_first;
    $rose(XFER_IN) && DIR_IN && SEL_IN == `GIOA_SEL_DISCRETE |-> s_first;
  endproperty
  a_ser_first: assert property (p_ser_first) else $error("first bit not msb");
endmodule // gioa_port_monitor
bind gioa_port gioa_port_monitor #(.TLM_MIN_CYC(TLM_MIN_CYC)) mon (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .XFER_IN(XFER_IN), .SEL_IN(SEL_IN),
  .DIR_IN(DIR_IN), .INIT_REQ_IN(INIT_REQ_IN), .INT_SRC_IN(INT_SRC_IN),
  .DISC_IN(DISC_IN), .SER_DATA_OUT(SER_DATA_OUT), .INTR_OUT(INTR_OUT),
  .COMP_INIT_OUT(COMP_INIT_OUT), .COMP_RUN_OUT(COMP_RUN_OUT), .DISC_OUT(DISC_OUT),
  .TLM_DATA_OUT(TLM_DATA_OUT), .TLM_STB_OUT(TLM_STB_OUT));

// *** verif/gioa_comp_model.sv ***
// computer side model: word transfers over the serial link
`timescale 1ns/10ps
module gioa_comp_model (
  // link to adapter
  output reg bit_clk_out,
  output reg xfer_out,
  output reg [7:0] sel_out,
  output reg dir_out,
  output reg ser_out,
  input wire ser_in
);
  initial begin
    bit_clk_out = 1'b0;
    xfer_out = 1'b0;
    sel_out = 8'h00;
    dir_out = 1'b0;
    ser_out = 1'b0;
  end
  // one word msb first, 160 ns bit time; n below 28 aborts
  task word(input [7:0] s, input d, input [27:0] w, input integer n, output [27:0] r);
    integer k;
    begin
      r = 28'h0;
      sel_out = s;
      dir_out = d;
      #40 xfer_out = 1'b1;
      #80;
      for (k = 0; k < n; k = k + 1) begin
        ser_out = w[27-k];
        #80 r = {r[26:0], ser_in};
        bit_clk_out = 1'b1;
        #80 bit_clk_out = 1'b0;
      end
      #40 xfer_out = 1'b0;
      // released lines stop showing the last value
      sel_out = ~s;
      dir_out = ~d;
      ser_out = ~ser_out;
      #160;
    end
  endtask
endmodule // gioa_comp_model

// *** verif/gioa_port_bench.sv ***
// self-checking bench of the adapter port
`timescale 1ns/10ps
`include "gioa_defs.vh"
module gioa_port_bench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg init_req = 1'b0;
  reg ce = 1'b1;
  reg cnt_pulse = 1'b0;
  reg [3:0] int_src = 4'h0;
  reg [27:0] disc_in = 28'h8c3a5e1;
  reg [27:0] rd;
  wire bclk, xfer, dir, sdi, sdo, intr, cinit, crun, stb;
  wire [7:0] sel;
  wire [27:0] disc_out, tlm;
  integer fail_count = 0;
  integer checks = 0;
  integer i;
  always #2 mclk = ~mclk;
  gioa_comp_model cm (.bit_clk_out(bclk), .xfer_out(xfer), .sel_out(sel),
    .dir_out(dir), .ser_out(sdi), .ser_in(sdo));
  gioa_port #(.TLM_MIN_CYC(2000), .TIMER_CYC(4000), .INIT_HOLD_CYC(5)) DUT (
    .MCLK_IN(mclk), .RST_IN(rst), .CE_IN(ce), .BIT_CLK_IN(bclk), .XFER_IN(xfer),
    .SEL_IN(sel), .DIR_IN(dir), .SER_DATA_IN(sdi), .SER_DATA_OUT(sdo),
    .INTR_OUT(intr), .INIT_REQ_IN(init_req), .COMP_INIT_OUT(cinit),
    .COMP_RUN_OUT(crun), .INT_SRC_IN(int_src), .DISC_IN(disc_in),
    .DISC_OUT(disc_out), .COUNT_PULSE_IN(cnt_pulse), .TLM_DATA_OUT(tlm),
    .TLM_STB_OUT(stb));
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input [63:0] nm, input [27:0] s, input [27:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("mismatch %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task wr(input [7:0] s, input [27:0] w, input integer n);
    cm.word(s, ~`GIOA_DIR_TO_COMP, w, n, rd);
  endtask
  task rdw(input [7:0] s);
    cm.word(s, `GIOA_DIR_TO_COMP, 28'h0, 28, rd);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_init;
    begin
      chk("init", cinit, 1);
      cyc(10);
      chk("run", crun, 1);
      init_req = 1'b1;
      cyc(6);
      chk("init", cinit, 1);
      init_req = 1'b0;
      cyc(6);
      chk("init", cinit, 1);
      cyc(8);
      chk("run", crun, 1);
      // enable low: a start-up request must not reach the outputs
      ce = 1'b0;
      init_req = 1'b1;
      cyc(6);
      chk("frozen", cinit, 0);
      init_req = 1'b0;
      cyc(4);
      ce = 1'b1;
      chk("frozen", crun, 1);
    end
  endtask
  task t_dline;
    begin
      for (i = 0; i < 16; i = i + 1) wr(`GIOA_SEL_DLINE, 28'h3000000 + i, 28);
      rdw(`GIOA_SEL_DLINE);
      chk("dline0", rd, 28'h3000000);
      rdw(`GIOA_SEL_DLINE);
      chk("dline1", rd, 28'h3000001);
    end
  endtask
  task t_disc;
    begin
      wr(`GIOA_SEL_DISCRETE, 28'h5a3c0f1, 28);
      chk("disc", disc_out, 28'h5a3c0f1);
      rdw(`GIOA_SEL_DISCRETE);
      chk("rdisc", rd, disc_in);
      wr(`GIOA_SEL_DISCRETE, 28'h1234567, 20);
      chk("abort", disc_out, 28'h5a3c0f1);
      wr(8'h7e, 28'hfffffff, 28);
      chk("unmap", disc_out, 28'h5a3c0f1);
      rdw(8'h7e);
      chk("unmapr", rd, 28'h0);
    end
  endtask
  task t_count;
    begin
      wr(`GIOA_SEL_COUNTER, 28'h00000fe, 28);
      repeat (3) begin
        cnt_pulse = 1'b1;
        cyc(4);
        cnt_pulse = 1'b0;
        cyc(4);
      end
      rdw(`GIOA_SEL_COUNTER);
      chk("count", rd, 28'h0000101);
    end
  endtask
  task t_tlm;
    begin
      wr(`GIOA_SEL_TLM, 28'h0abcdef, 28);
      chk("tlm", tlm, 28'h0abcdef);
      wr(`GIOA_SEL_TLM, 28'h0123456, 28);
      chk("tlmwait", tlm, 28'h0abcdef);
      for (i = 0; i < 3000 && tlm !== 28'h0123456; i = i + 1) cyc(1);
      chk("tlm2", tlm, 28'h0123456);
      chk("stb", stb, 1);
      cyc(1);
      chk("stb", stb, 0);
    end
  endtask
  task t_intr;
    begin
      rdw(`GIOA_SEL_INTSTAT);
      cyc(4);
      chk("intr", intr, 0);
      int_src = 4'h4;
      cyc(12);
      chk("intr", intr, 1);
      rdw(`GIOA_SEL_INTSTAT);
      chk("istat", rd, 28'h0000004);
      int_src = 4'h0;
      cyc(12);
      chk("intr", intr, 0);
      for (i = 0; i < 4100 && intr !== 1'b1; i = i + 1) cyc(1);
      chk("timer", intr, 1);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    cyc(16);
    rst = 1'b0;
    t_init;
    t_dline;
    t_disc;
    t_count;
    t_tlm;
    t_intr;
    conclude;
  end
  initial begin
    #400000;
    fail_count = fail_count + 1;
    conclude;
  end
endmodule // gioa_port_bench
